// ### pkg/din_debounce_pkg.sv
// Constants for the digital input debounce and edge counter block.
// Assumes a 25 MHz system clock; sampling ticks are derived from it.
`default_nettype none
package din_debounce_pkg;

  // System clock period and sampling period, in ns
  localparam int CLK_PERIOD_NS    = 40;
  localparam int SAMPLE_PERIOD_NS = 800;
  // Sampling tick divider count, rounded down, at least one cycle
  localparam int SAMPLE_DIV = (SAMPLE_PERIOD_NS / CLK_PERIOD_NS) < 1 ? 1 :
                              (SAMPLE_PERIOD_NS / CLK_PERIOD_NS);
  localparam int DIV_W      = $clog2(SAMPLE_DIV + 1);

  // Field widths and reset values
  localparam int EDGE_CNT_W    = 32;
  localparam int HALF_W        = EDGE_CNT_W / 2;
  localparam int DEB_TIME_W    = 5;
  localparam int DEB_CNT_W     = 17;
  localparam logic [DEB_TIME_W-1:0] DEB_BYPASS = 5'h00;
  localparam logic [EDGE_CNT_W-1:0] EDGE_CNT_RST = 32'h0000_0000;
  localparam logic [DEB_CNT_W-1:0]  DEB_CNT_RST  = 17'h0_0000;

  // Debounce durations per code, in ns (code 0 is bypass)
  localparam int DEB_TIME_NS [0:31] = '{
    0, 13000, 18700, 24400, 32500, 42300, 56100, 75600,
    100800, 130100, 180500, 240600, 320300, 420300, 560200, 750400,
    1000800, 1300800, 1800800, 2400800, 3200800, 4200800, 5600800,
    7500700, 10000700, 13000700, 18000600, 24000600, 32000500,
    42000400, 56000300, 75000000};

  // Target count in samples: duration / sample period, rounded
  function automatic logic [DEB_CNT_W-1:0] deb_target(
      input logic [DEB_TIME_W-1:0] code);
    int t;
    t = (DEB_TIME_NS[code] + SAMPLE_PERIOD_NS / 2) / SAMPLE_PERIOD_NS;
    if (t < 1) begin
      t = 1;
    end
    return t[DEB_CNT_W-1:0];
  endfunction

endpackage
`default_nettype wire

// ### rtl/digital_input_debounce_counter.sv
// Digital input conditioning for one channel: source select, sampling,
// two-mode debounce, optional inversion and a 32-bit edge counter.
// Assumes the comparator outputs are asynchronous to sys_clk and that
// configuration ports are driven from sys_clk logic.
`timescale 1ns/1ps
`default_nettype none
module digital_input_debounce_counter (
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  resetn,
  // Comparator outputs for the two sources
  input  wire logic                  cmpBufferedSense,
  input  wire logic                  cmpChannelOutput,
  // Configuration
  input  wire logic                  inputSelect,
  input  wire logic                  thresholdReferenceSelect,
  input  wire logic                  filteredOutputInvert,
  input  wire logic                  debounceMode,
  input  wire logic [4:0]            debounceTime,
  input  wire logic                  countEnable,
  // Status and pins
  output logic                       thresholdRefSel_r,
  output logic                       compOutStatus_r,
  output logic                       gpioOut_r,
  output logic [15:0]                countLow_r,
  output logic [15:0]                countHigh_r
);

  // ************************************************************
  // Reset synchroniser
  // ************************************************************
  logic rstMeta_r;
  logic rstSync_r;

  // Asserts at once, releases after two edges
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rstMeta_r <= 1'b0;
      rstSync_r <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstSync_r <= rstMeta_r;
    end
  end

  // ************************************************************
  // Sampling tick and input synchronisers
  // ************************************************************
  localparam int DW = din_debounce_pkg::DIV_W;
  logic [DW-1:0] divCnt_r;
  logic          sampleTick_r;
  logic          bufMeta_r;
  logic          bufSync_r;
  logic          outMeta_r;
  logic          outSync_r;
  logic          sample_r;

  // One-cycle enable every sampling period
  always_ff @(posedge sys_clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      divCnt_r     <= '0;
      sampleTick_r <= 1'b0;
    end else if (divCnt_r == DW'(din_debounce_pkg::SAMPLE_DIV - 1)) begin
      divCnt_r     <= '0;
      sampleTick_r <= 1'b1;
    end else begin
      divCnt_r     <= divCnt_r + DW'(1);
      sampleTick_r <= 1'b0;
    end
  end

  // Two flip-flops per comparator source
  always_ff @(posedge sys_clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      bufMeta_r <= 1'b0;
      bufSync_r <= 1'b0;
      outMeta_r <= 1'b0;
      outSync_r <= 1'b0;
    end else begin
      bufMeta_r <= cmpBufferedSense;
      bufSync_r <= bufMeta_r;
      outMeta_r <= cmpChannelOutput;
      outSync_r <= outMeta_r;
    end
  end

  // Source select and sample on the tick
  always_ff @(posedge sys_clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      sample_r <= 1'b0;
    end else if (sampleTick_r) begin
      sample_r <= inputSelect ? outSync_r : bufSync_r;
    end
  end

  // Threshold reference select, registered to the comparator
  always_ff @(posedge sys_clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      thresholdRefSel_r <= 1'b0;
    end else begin
      thresholdRefSel_r <= thresholdReferenceSelect;
    end
  end

  // ************************************************************
  // Debounce
  // ************************************************************
  localparam int CW = din_debounce_pkg::DEB_CNT_W;
  logic [CW-1:0] target;
  logic [CW-1:0] debCnt_r;
  logic          debounced_r;
  logic          sampleValid_r;

  // Target samples per code
  assign target = din_debounce_pkg::deb_target(debounceTime);

  // Sample is updated one cycle after the tick
  always_ff @(posedge sys_clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      sampleValid_r <= 1'b0;
    end else begin
      sampleValid_r <= sampleTick_r;
    end
  end

  // Debounce counter and debounced state, stepped once per sample
  always_ff @(posedge sys_clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      debCnt_r    <= din_debounce_pkg::DEB_CNT_RST;
      debounced_r <= 1'b0;
    end else if (sampleValid_r) begin
      if (debounceTime == din_debounce_pkg::DEB_BYPASS) begin
        debounced_r <= sample_r;
        debCnt_r    <= din_debounce_pkg::DEB_CNT_RST;
      end else if (!debounceMode) begin
        // Mode 0: count toward target while differing, back when not
        if (sample_r != debounced_r) begin
          if (debCnt_r + CW'(1) >= target) begin
            debounced_r <= sample_r;
            debCnt_r    <= din_debounce_pkg::DEB_CNT_RST;
          end else begin
            debCnt_r <= debCnt_r + CW'(1);
          end
        end else if (debCnt_r != '0) begin
          debCnt_r <= debCnt_r - CW'(1);
        end
      end else begin
        // Mode 1: new state must persist for the full time
        if (sample_r == debounced_r) begin
          debCnt_r <= din_debounce_pkg::DEB_CNT_RST;
        end else if (debCnt_r + CW'(1) >= target) begin
          debounced_r <= sample_r;
          debCnt_r    <= din_debounce_pkg::DEB_CNT_RST;
        end else begin
          debCnt_r <= debCnt_r + CW'(1);
        end
      end
    end
  end

  // ************************************************************
  // Output inversion and edge counter
  // ************************************************************
  localparam int EW = din_debounce_pkg::EDGE_CNT_W;
  localparam int HW = din_debounce_pkg::HALF_W;
  logic          conditioned;
  logic          condPrev_r;
  logic [EW-1:0] edgeCnt_r;
  logic          risingEdge;

  // Inverter ahead of status, pin and edge detect
  assign conditioned = debounced_r ^ filteredOutputInvert;
  assign risingEdge  = conditioned & ~condPrev_r;

  // Status bit and pin copy
  always_ff @(posedge sys_clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      compOutStatus_r <= 1'b0;
      gpioOut_r       <= 1'b0;
      condPrev_r      <= 1'b0;
    end else begin
      compOutStatus_r <= conditioned;
      gpioOut_r       <= conditioned;
      condPrev_r      <= conditioned;
    end
  end

  // Free wrapping edge counter
  always_ff @(posedge sys_clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      edgeCnt_r <= din_debounce_pkg::EDGE_CNT_RST;
    end else if (countEnable && risingEdge) begin
      edgeCnt_r <= edgeCnt_r + EW'(1);
    end
  end

  // Halves for software
  always_ff @(posedge sys_clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      countLow_r  <= '0;
      countHigh_r <= '0;
    end else begin
      countLow_r  <= edgeCnt_r[HW-1:0];
      countHigh_r <= edgeCnt_r[EW-1:HW];
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  AST_COUNT_STEP: assert property (@(posedge sys_clk) disable iff (!rstSync_r)
    countEnable && risingEdge |=> edgeCnt_r == $past(edgeCnt_r) + EW'(1))
    else $error("edge counter did not step");
  AST_COUNT_HOLD: assert property (@(posedge sys_clk) disable iff (!rstSync_r)
    !countEnable |=> edgeCnt_r == $past(edgeCnt_r))
    else $error("edge counter moved while disabled");
  AST_HALVES: assert property (@(posedge sys_clk) disable iff (!rstSync_r)
    1'b1 |=> {countHigh_r, countLow_r} == $past(edgeCnt_r))
    else $error("count halves mismatch");
  AST_WRAP: assert property (@(posedge sys_clk) disable iff (!rstSync_r)
    countEnable && risingEdge && (&edgeCnt_r) |=> edgeCnt_r == '0)
    else $error("counter did not wrap");
  AST_BYPASS: assert property (@(posedge sys_clk) disable iff (!rstSync_r)
    sampleValid_r && debounceTime == din_debounce_pkg::DEB_BYPASS
    |=> debounced_r == $past(sample_r))
    else $error("bypass did not pass sample");
  AST_M1_RESET: assert property (@(posedge sys_clk) disable iff (!rstSync_r)
    sampleValid_r && debounceMode && sample_r == debounced_r
    |=> debCnt_r == '0)
    else $error("mode 1 count not cleared");
  AST_M0_DOWN: assert property (@(posedge sys_clk) disable iff (!rstSync_r)
    sampleValid_r && !debounceMode
    && debounceTime != din_debounce_pkg::DEB_BYPASS
    && sample_r == debounced_r && debCnt_r != '0
    |=> debCnt_r == $past(debCnt_r) - CW'(1))
    else $error("mode 0 did not count back");
  AST_STATUS: assert property (@(posedge sys_clk) disable iff (!rstSync_r)
    1'b1 |=> compOutStatus_r ==
    ($past(debounced_r) ^ $past(filteredOutputInvert))
    && gpioOut_r == compOutStatus_r)
    else $error("status not the inverted result");
  AST_TICK: assert property (@(posedge sys_clk) disable iff (!rstSync_r)
    sampleTick_r |=> !sampleTick_r [*8])
    else $error("sampling ticks too close");

endmodule
`default_nettype wire

// ### bench/comparator_model.sv
// Behavioural threshold comparator pair that feeds one input channel.
// Assumes the bench sets, just after a clock edge, whether the field
// level is above threshold on the buffered and the unbuffered path.
`timescale 1ns/1ps
`default_nettype none
module comparator_model (
  // Field level above threshold, per path
  input  wire logic bufAbove,
  input  wire logic fastAbove,
  // Comparator outputs towards the block
  output logic      cmpBufferedSense,
  output logic      cmpChannelOutput
);
  // ****************************************
  // Comparator decisions
  // ****************************************
  // Both paths are plain levels, asynchronous to the sampling clock
  assign cmpBufferedSense = bufAbove;
  assign cmpChannelOutput = fastAbove;
endmodule
`default_nettype wire

// ### bench/tb_top.sv
// Self-checking bench for the debounce and edge counter block.
// Assumes a 25 MHz clock, and that status changes come in queued order.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ****************************************
  // Signals and instances
  // ****************************************
  logic        sys_clk, resetn, bufLvl, fastLvl, inSel, refSel, inv, mode, cen;
  logic [4:0]  dTime;
  logic        refSelOut, st, gpio, prevSt, rndBit;
  logic [15:0] cLo, cHi;
  logic        bufCmp, fastCmp;
  logic [31:0] expCount;
  logic        expQ[$];
  int          mismatches, tests_run, cycles, tgt, seedv;

  comparator_model cmp_u (.bufAbove(bufLvl), .fastAbove(fastLvl),
    .cmpBufferedSense(bufCmp), .cmpChannelOutput(fastCmp));
  digital_input_debounce_counter dut_u (.sys_clk(sys_clk), .resetn(resetn),
    .cmpBufferedSense(bufCmp), .cmpChannelOutput(fastCmp),
    .inputSelect(inSel), .thresholdReferenceSelect(refSel),
    .filteredOutputInvert(inv), .debounceMode(mode), .debounceTime(dTime),
    .countEnable(cen), .thresholdRefSel_r(refSelOut),
    .compOutStatus_r(st), .gpioOut_r(gpio), .countLow_r(cLo),
    .countHigh_r(cHi));

  // Clock generation
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic setIn(input logic b, input logic f);
    @(posedge sys_clk);
    bufLvl  <= b;
    fastLvl <= f;
  endtask
  // Full high then low pulse, each status change noted in order
  task automatic pulse(input int hi, input int lo);
    expQ.push_back(1'b1);
    expQ.push_back(1'b0);
    setIn(1'b1, 1'b1);
    cyc(hi);
    setIn(1'b0, 1'b0);
    cyc(lo);
  endtask
  task automatic print_verdict;
    if (expQ.size() != 0) mismatches++;
    $display("tests_run %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // ****************************************
  // Output watcher and timeout
  // ****************************************
  // Each status change takes the oldest queued note
  always @(posedge sys_clk) begin
    if (resetn && gpio !== st) chk("gpio", {31'h0, st}, {31'h0, gpio});
    if (st !== prevSt) begin
      if (expQ.size() == 0) chk("status change", {31'h0, prevSt}, {31'h0, st});
      else chk("status", {31'h0, expQ.pop_front()}, {31'h0, st});
      prevSt = st;
    end
  end
  // Cuts a hang short
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 12000) begin
      mismatches++;
      print_verdict;
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {resetn, bufLvl, fastLvl, inSel, refSel, inv, mode, cen} = 8'h00;
    dTime = 5'h00;
    prevSt = 1'b0;
    expCount = 32'h0;
    seedv = $urandom(90);
    cyc(8);
    resetn <= 1'b1;
    cyc(5);
    chk("count after reset", expCount, {cHi, cLo});
    @(posedge sys_clk) cen <= 1'b1;
    // Bypass: status follows input, rising edges counted
    for (int i = 0; i < 4; i++) begin
      pulse(25 + $urandom % 20, 25 + $urandom % 20);
      expCount++;
    end
    chk("count bypass", expCount, {cHi, cLo});
    // Inverter on: the toggle itself is a counted rising edge
    expQ.push_back(1'b1);
    @(posedge sys_clk) inv <= 1'b1;
    expCount++;
    cyc(30);
    expQ.push_back(1'b0);
    expQ.push_back(1'b1);
    setIn(1'b1, 1'b1);
    cyc(30);
    setIn(1'b0, 1'b0);
    cyc(30);
    expCount++;
    chk("count inverted", expCount, {cHi, cLo});
    expQ.push_back(1'b0);
    @(posedge sys_clk) inv <= 1'b0;
    cyc(30);
    // Frozen counter ignores edges, then resumes
    @(posedge sys_clk) cen <= 1'b0;
    pulse(30, 30);
    pulse(30, 30);
    chk("count frozen", expCount, {cHi, cLo});
    @(posedge sys_clk) cen <= 1'b1;
    pulse(30, 30);
    expCount++;
    chk("count resumed", expCount, {cHi, cLo});
    // Source select: only the chosen path reaches the status
    @(posedge sys_clk) inSel <= 1'b1;
    setIn(1'b1, 1'b0);
    cyc(60);
    expQ.push_back(1'b1);
    setIn(1'($urandom % 2), 1'b1);
    cyc(30);
    chk("unbuffered path", 32'h1, {31'h0, st});
    expQ.push_back(1'b0);
    setIn(1'b0, 1'b0);
    cyc(30);
    expCount++;
    @(posedge sys_clk) inSel <= 1'b0;
    // Threshold reference select is forwarded
    rndBit = 1'($urandom % 2);
    @(posedge sys_clk) refSel <= rndBit;
    cyc(3);
    chk("ref select", {31'h0, rndBit}, {31'h0, refSelOut});
    @(posedge sys_clk) refSel <= ~rndBit;
    cyc(3);
    chk("ref select", {31'h0, ~rndBit}, {31'h0, refSelOut});
    // Persist mode: a short high is dropped, a full one is taken
    tgt = (din_debounce_pkg::DEB_TIME_NS[1] + 400) / 800;
    @(posedge sys_clk) mode <= 1'b1;
    dTime <= 5'h01;
    setIn(1'b1, 1'b1);
    cyc(240);
    setIn(1'b0, 1'b0);
    cyc(tgt * 20 + 40);
    expQ.push_back(1'b1);
    setIn(1'b1, 1'b1);
    cyc(tgt * 20 - 25);
    chk("persist early", 32'h0, {31'h0, st});
    cyc(60);
    chk("persist done", 32'h1, {31'h0, st});
    expCount++;
    expQ.push_back(1'b0);
    setIn(1'b0, 1'b0);
    cyc(tgt * 20 + 40);
    // Up/down mode: a short revert only steps the count back
    @(posedge sys_clk) mode <= 1'b0;
    expQ.push_back(1'b1);
    setIn(1'b1, 1'b1);
    cyc(200);
    setIn(1'b0, 1'b0);
    cyc(80);
    setIn(1'b1, 1'b1);
    cyc(290);
    chk("updown done", 32'h1, {31'h0, st});
    expCount++;
    @(posedge sys_clk) dTime <= 5'h00;
    expQ.push_back(1'b0);
    setIn(1'b0, 1'b0);
    cyc(30);
    chk("count final", expCount, {cHi, cLo});
    print_verdict;
  end
endmodule
`default_nettype wire
